// ### ban_pkg.sv
// Contract
// R1: Negotiation runs only while the enable control is set.
// R2: Skip control stops negotiation yet connects the PCS to the output; the code connects it only while enable is also set.
// R3: An 8-bit seed initialises the nonce generator of the codeword.
// R4: Random bit generator uses x^7+x^6+1 when select is 1, else x^7+x^3+1.
// R5: Restart begins negotiation again from any state; the code ignores it while enable is clear or skip is set.
// R6: Fault control is copied into the fault flag of the sent codeword.
// R7: Pause control is copied into codeword bit C0.
// R8: Asymmetric-direction control is copied into codeword bit C1.
// R9: Local request set sends the local next-page word; clear never starts the exchange.
// R10: Partner next pages with local request clear are answered by null message pages.
// R11: Host raises read acknowledge only after reading the partner next-page word.
// R12: Read acknowledge makes us acknowledge the partner page, then send the next.
// R13: After acknowledge the partner page valid flag stays low until a new page.
// R14: Each ability bit set advertises that protocol in the sent codeword.
// R15: All controls and handshake signals are sampled on the rising clock edge.
package ban_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int ADDR_WIDTH = 8;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_ADVERTISE = 8'h04;
	localparam logic [7:0] OFS_SEED = 8'h08;
	localparam logic [7:0] OFS_LOCAL_PAGE_LO = 8'h0c;
	localparam logic [7:0] OFS_LOCAL_PAGE_HI = 8'h10;
	localparam logic [7:0] OFS_PARTNER_PAGE_LO = 8'h14;
	localparam logic [7:0] OFS_PARTNER_PAGE_HI = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register fields
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_BYPASS_BIT = 1;
	localparam int CTL_RESTART_BIT = 2;
	localparam int CTL_POLY_BIT = 3;
	localparam int CTL_LOCAL_REQ_BIT = 4;
	localparam int CTL_READ_ACK_BIT = 5;

	// Advertise register fields
	localparam int ADV_FAULT_BIT = 0;
	localparam int ADV_PAUSE_BIT = 1;
	localparam int ADV_ASYM_BIT = 2;
	localparam int ADV_ABILITY_LSB = 8;
	localparam int ABILITY_WIDTH = 15;

	// Status register fields
	localparam int STS_ACTIVE_BIT = 0;
	localparam int STS_PCS_BIT = 1;
	localparam int STS_PARTNER_VALID_BIT = 2;
	localparam int STS_DONE_BIT = 3;
	localparam int STS_PARTNER_NP_BIT = 4;

	// Reset values
	localparam logic [7:0] SEED_RESET = 8'h01;
	localparam logic [6:0] RANDOM_SEED = 7'h01;

	// ************************************************************
	// Link codeword layout
	// ************************************************************
	localparam int PAGE_WIDTH = 48;
	localparam int CW_SELECTOR_LSB = 0;
	localparam int SELECTOR_WIDTH = 5;
	localparam logic [4:0] SELECTOR_VALUE = 5'h01;
	localparam int CW_ECHO_LSB = 5;
	localparam int CW_C0_BIT = 10;
	localparam int CW_C1_BIT = 11;
	localparam int CW_FAULT_BIT = 13;
	localparam int CW_ACK_BIT = 14;
	localparam int CW_NP_BIT = 15;
	localparam int CW_NONCE_LSB = 16;
	localparam int NONCE_WIDTH = 5;
	localparam int CW_ABILITY_LSB = 21;
	localparam logic [47:0] NULL_MESSAGE = 48'h000000000001;

	// ************************************************************
	// Random generators
	// ************************************************************
	localparam logic [7:0] NONCE_TAPS = 8'hb8;
	localparam logic [6:0] POLY_X7_X6_TAPS = 7'h60;
	localparam logic [6:0] POLY_X7_X3_TAPS = 7'h44;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int PAGE_INTERVAL_NS = 10000;
	localparam int PAGE_CYCLES = (PAGE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_CNT_WIDTH = 7;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} ban_axil_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} ban_axil_rsp_type;

	typedef struct packed {
		logic [47:0] word;
		logic strobe;
	} ban_page_type;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_BYPASS,
		ST_BASE,
		ST_BASE_ACK,
		ST_NEXT,
		ST_HOST_WAIT,
		ST_NEXT_ACK,
		ST_DONE
	} ban_state_type;

endpackage

// ### ban_lfsr.sv
// ************************************************************
// Shift register generator with selectable taps
// ************************************************************
module ban_lfsr #(
	parameter int WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [WIDTH-1:0] seed,
	input wire logic step,
	input wire logic [WIDTH-1:0] taps,
	output logic [WIDTH-1:0] state
);

	logic [WIDTH-1:0] one;
	logic feedback;

	// All-zero state would lock up, so it is replaced by one
	assign one = {{(WIDTH-1){1'b0}}, 1'b1};
	assign feedback = ^(state & taps);

	// Load has priority over step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= {{(WIDTH-1){1'b0}}, 1'b1};
		end else if (load) begin
			state <= (seed == '0) ? one : seed;
		end else if (step) begin
			state <= {state[WIDTH-2:0], feedback};
		end
	end

endmodule // ban_lfsr

// ### ban_autoneg_control.sv
// ************************************************************
// Backplane auto-negotiation control
// ************************************************************
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
module ban_autoneg_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire ban_pkg::ban_axil_req_type axil_req,
	output ban_pkg::ban_axil_rsp_type axil_rsp,
	input wire ban_pkg::ban_page_type rx_page,
	output ban_pkg::ban_page_type tx_page,
	output logic tx_random_bit,
	output logic pcs_connect,
	output logic negotiation_active
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic autoneg_enable;
	logic autoneg_bypass;
	logic random_bit_poly_select;
	logic local_next_page_request;
	logic advertise_fault_in;
	logic advertise_pause_in;
	logic advertise_asym_direction_in;
	logic [14:0] ability;
	logic [7:0] nonce_generator_seed;
	logic [47:0] local_next_page_word;
	logic restart_pulse;
	logic partner_page_read_ack;
	logic [47:0] partner_next_page_word;
	logic partner_next_page_valid;
	logic [47:0] partner_base_word;
	logic partner_np;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic next_aw_held;
	logic next_w_held;
	logic next_bvalid;
	logic next_rvalid;
	logic [31:0] merged;
	logic [31:0] read_data;
	logic read_hit;
	logic write_hit;
	ban_pkg::ban_state_type state;
	ban_pkg::ban_state_type next_state;
	logic [6:0] page_count;
	logic page_due;
	logic sending;
	logic [47:0] next_tx_word;
	logic [7:0] nonce_state;
	logic [6:0] random_state;
	logic [6:0] random_taps;
	logic nonce_load;
	logic next_active;
	logic page_fire;

	// ************************************************************
	// AXI4-Lite handshakes
	// ************************************************************

	// Channel take events and the write commit point
	assign aw_take = axil_rsp.awready & axil_req.awvalid;
	assign w_take = axil_rsp.wready & axil_req.wvalid;
	assign ar_take = axil_rsp.arready & axil_req.arvalid;
	assign do_write = aw_held & w_held & ~axil_rsp.bvalid;
	assign next_aw_held = do_write ? 1'b0 : (aw_held | aw_take);
	assign next_w_held = do_write ? 1'b0 : (w_held | w_take);
	assign next_bvalid = do_write | (axil_rsp.bvalid & ~axil_req.bready);
	assign next_rvalid = ar_take | (axil_rsp.rvalid & ~axil_req.rready);

	// Address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			if (aw_take) begin
				aw_addr <= axil_req.awaddr;
			end
			if (w_take) begin
				w_data <= axil_req.wdata;
				w_strb <= axil_req.wstrb;
			end
		end
	end

	// Ready and response flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			axil_rsp.awready <= 1'b0;
			axil_rsp.wready <= 1'b0;
			axil_rsp.bvalid <= 1'b0;
			axil_rsp.bresp <= 2'h0;
			axil_rsp.arready <= 1'b0;
			axil_rsp.rvalid <= 1'b0;
			axil_rsp.rresp <= 2'h0;
			axil_rsp.rdata <= 32'h00000000;
		end else begin
			axil_rsp.awready <= ~next_aw_held & ~next_bvalid;
			axil_rsp.wready <= ~next_w_held & ~next_bvalid;
			axil_rsp.bvalid <= next_bvalid;
			axil_rsp.arready <= ~next_rvalid;
			axil_rsp.rvalid <= next_rvalid;
			if (do_write) begin
				axil_rsp.bresp <= write_hit ? ban_pkg::RESP_OKAY : ban_pkg::RESP_SLVERR;
			end
			if (ar_take) begin
				axil_rsp.rdata <= read_data;
				axil_rsp.rresp <= read_hit ? ban_pkg::RESP_OKAY : ban_pkg::RESP_SLVERR;
			end
		end
	end

	// ************************************************************
	// Register file
	// ************************************************************

	// Byte strobes merged onto the current register value
	always_comb begin
		merged = 32'h00000000;
		if (aw_addr == ban_pkg::OFS_CONTROL) begin
			merged[ban_pkg::CTL_ENABLE_BIT] = autoneg_enable;
			merged[ban_pkg::CTL_BYPASS_BIT] = autoneg_bypass;
			merged[ban_pkg::CTL_POLY_BIT] = random_bit_poly_select;
			merged[ban_pkg::CTL_LOCAL_REQ_BIT] = local_next_page_request;
		end else if (aw_addr == ban_pkg::OFS_ADVERTISE) begin
			merged[ban_pkg::ADV_FAULT_BIT] = advertise_fault_in;
			merged[ban_pkg::ADV_PAUSE_BIT] = advertise_pause_in;
			merged[ban_pkg::ADV_ASYM_BIT] = advertise_asym_direction_in;
			merged[ban_pkg::ADV_ABILITY_LSB +: ban_pkg::ABILITY_WIDTH] = ability;
		end else if (aw_addr == ban_pkg::OFS_SEED) begin
			merged[7:0] = nonce_generator_seed;
		end else if (aw_addr == ban_pkg::OFS_LOCAL_PAGE_LO) begin
			merged = local_next_page_word[31:0];
		end else if (aw_addr == ban_pkg::OFS_LOCAL_PAGE_HI) begin
			merged[15:0] = local_next_page_word[47:32];
		end
		for (int i = 0; i < 4; i++) begin
			if (w_strb[i]) begin
				merged[i*8 +: 8] = w_data[i*8 +: 8];
			end
		end
	end

	// Writable offsets
	always_comb begin
		write_hit = 1'b0;
		if (aw_addr == ban_pkg::OFS_CONTROL) begin
			write_hit = 1'b1;
		end else if (aw_addr == ban_pkg::OFS_ADVERTISE) begin
			write_hit = 1'b1;
		end else if (aw_addr == ban_pkg::OFS_SEED) begin
			write_hit = 1'b1;
		end else if (aw_addr == ban_pkg::OFS_LOCAL_PAGE_LO) begin
			write_hit = 1'b1;
		end else if (aw_addr == ban_pkg::OFS_LOCAL_PAGE_HI) begin
			write_hit = 1'b1;
		end
	end

	// Control storage, restart and acknowledge are one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			autoneg_enable <= 1'b0;
			autoneg_bypass <= 1'b0;
			random_bit_poly_select <= 1'b0;
			local_next_page_request <= 1'b0;
			advertise_fault_in <= 1'b0;
			advertise_pause_in <= 1'b0;
			advertise_asym_direction_in <= 1'b0;
			ability <= 15'h0000;
			nonce_generator_seed <= ban_pkg::SEED_RESET;
			local_next_page_word <= 48'h000000000000;
			restart_pulse <= 1'b0;
			partner_page_read_ack <= 1'b0;
		end else begin
			restart_pulse <= 1'b0;
			partner_page_read_ack <= 1'b0;
			if (do_write) begin // R15
				if (aw_addr == ban_pkg::OFS_CONTROL) begin
					autoneg_enable <= merged[ban_pkg::CTL_ENABLE_BIT];
					autoneg_bypass <= merged[ban_pkg::CTL_BYPASS_BIT];
					random_bit_poly_select <= merged[ban_pkg::CTL_POLY_BIT];
					local_next_page_request <= merged[ban_pkg::CTL_LOCAL_REQ_BIT];
					restart_pulse <= merged[ban_pkg::CTL_RESTART_BIT];
					partner_page_read_ack <= merged[ban_pkg::CTL_READ_ACK_BIT];
				end else if (aw_addr == ban_pkg::OFS_ADVERTISE) begin
					advertise_fault_in <= merged[ban_pkg::ADV_FAULT_BIT];
					advertise_pause_in <= merged[ban_pkg::ADV_PAUSE_BIT];
					advertise_asym_direction_in <= merged[ban_pkg::ADV_ASYM_BIT];
					ability <= merged[ban_pkg::ADV_ABILITY_LSB +: ban_pkg::ABILITY_WIDTH];
				end else if (aw_addr == ban_pkg::OFS_SEED) begin
					nonce_generator_seed <= merged[7:0];
				end else if (aw_addr == ban_pkg::OFS_LOCAL_PAGE_LO) begin
					local_next_page_word[31:0] <= merged;
				end else if (aw_addr == ban_pkg::OFS_LOCAL_PAGE_HI) begin
					local_next_page_word[47:32] <= merged[15:0];
				end
			end
		end
	end

	// Read decode, unmapped offsets answer zero with an error
	always_comb begin
		read_data = 32'h00000000;
		read_hit = 1'b1;
		if (axil_req.araddr == ban_pkg::OFS_CONTROL) begin
			read_data[ban_pkg::CTL_ENABLE_BIT] = autoneg_enable;
			read_data[ban_pkg::CTL_BYPASS_BIT] = autoneg_bypass;
			read_data[ban_pkg::CTL_POLY_BIT] = random_bit_poly_select;
			read_data[ban_pkg::CTL_LOCAL_REQ_BIT] = local_next_page_request;
		end else if (axil_req.araddr == ban_pkg::OFS_ADVERTISE) begin
			read_data[ban_pkg::ADV_FAULT_BIT] = advertise_fault_in;
			read_data[ban_pkg::ADV_PAUSE_BIT] = advertise_pause_in;
			read_data[ban_pkg::ADV_ASYM_BIT] = advertise_asym_direction_in;
			read_data[ban_pkg::ADV_ABILITY_LSB +: ban_pkg::ABILITY_WIDTH] = ability;
		end else if (axil_req.araddr == ban_pkg::OFS_SEED) begin
			read_data[7:0] = nonce_generator_seed;
		end else if (axil_req.araddr == ban_pkg::OFS_LOCAL_PAGE_LO) begin
			read_data = local_next_page_word[31:0];
		end else if (axil_req.araddr == ban_pkg::OFS_LOCAL_PAGE_HI) begin
			read_data[15:0] = local_next_page_word[47:32];
		end else if (axil_req.araddr == ban_pkg::OFS_PARTNER_PAGE_LO) begin
			read_data = partner_next_page_word[31:0];
		end else if (axil_req.araddr == ban_pkg::OFS_PARTNER_PAGE_HI) begin
			read_data[15:0] = partner_next_page_word[47:32];
		end else if (axil_req.araddr == ban_pkg::OFS_STATUS) begin
			read_data[ban_pkg::STS_ACTIVE_BIT] = negotiation_active;
			read_data[ban_pkg::STS_PCS_BIT] = pcs_connect;
			read_data[ban_pkg::STS_PARTNER_VALID_BIT] = partner_next_page_valid;
			read_data[ban_pkg::STS_DONE_BIT] = (state == ban_pkg::ST_DONE);
			read_data[ban_pkg::STS_PARTNER_NP_BIT] = partner_np;
		end else begin
			read_hit = 1'b0;
		end
	end

	// ************************************************************
	// Negotiation sequence
	// ************************************************************

	// Enable, then skip, then restart take priority over progress
	always_comb begin
		next_state = state;
		if (!autoneg_enable) begin
			next_state = ban_pkg::ST_OFF; // R1
		end else if (autoneg_bypass) begin
			next_state = ban_pkg::ST_BYPASS; // R2
		end else if (restart_pulse) begin
			next_state = ban_pkg::ST_BASE; // R5
		end else begin
			case (state)
				ban_pkg::ST_OFF, ban_pkg::ST_BYPASS: begin
					next_state = ban_pkg::ST_BASE;
				end
				ban_pkg::ST_BASE: begin
					if (rx_page.strobe) begin
						next_state = ban_pkg::ST_BASE_ACK;
					end
				end
				ban_pkg::ST_BASE_ACK, ban_pkg::ST_NEXT_ACK: begin
					if (rx_page.strobe && rx_page.word[ban_pkg::CW_ACK_BIT]) begin
						if (local_next_page_request || partner_np) begin
							next_state = ban_pkg::ST_NEXT; // R9 R10
						end else begin
							next_state = ban_pkg::ST_DONE;
						end
					end
				end
				ban_pkg::ST_NEXT: begin
					if (rx_page.strobe) begin
						next_state = ban_pkg::ST_HOST_WAIT;
					end
				end
				ban_pkg::ST_HOST_WAIT: begin
					if (partner_page_read_ack) begin
						next_state = ban_pkg::ST_NEXT_ACK; // R11 R12
					end
				end
				default: begin
					next_state = state;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ban_pkg::ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Partner pages captured as they arrive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			partner_base_word <= 48'h000000000000;
			partner_next_page_word <= 48'h000000000000;
			partner_next_page_valid <= 1'b0;
			partner_np <= 1'b0;
		end else if (next_state == ban_pkg::ST_OFF || next_state == ban_pkg::ST_BYPASS || restart_pulse) begin
			partner_next_page_valid <= 1'b0;
			partner_np <= 1'b0;
		end else if (state == ban_pkg::ST_BASE && rx_page.strobe) begin // R15
			partner_base_word <= rx_page.word;
			partner_np <= rx_page.word[ban_pkg::CW_NP_BIT];
		end else if (state == ban_pkg::ST_NEXT && rx_page.strobe) begin
			partner_next_page_word <= rx_page.word;
			partner_np <= rx_page.word[ban_pkg::CW_NP_BIT];
			partner_next_page_valid <= 1'b1;
		end else if (state == ban_pkg::ST_HOST_WAIT && partner_page_read_ack) begin
			partner_next_page_valid <= 1'b0; // R13
		end
	end

	// ************************************************************
	// Transmit codeword
	// ************************************************************

	// Base page or next page assembled from the controls
	always_comb begin
		next_tx_word = 48'h000000000000;
		if (state == ban_pkg::ST_BASE || state == ban_pkg::ST_BASE_ACK) begin
			next_tx_word[ban_pkg::CW_SELECTOR_LSB +: ban_pkg::SELECTOR_WIDTH] = ban_pkg::SELECTOR_VALUE;
			next_tx_word[ban_pkg::CW_ECHO_LSB +: ban_pkg::NONCE_WIDTH] =
				partner_base_word[ban_pkg::CW_NONCE_LSB +: ban_pkg::NONCE_WIDTH];
			next_tx_word[ban_pkg::CW_C0_BIT] = advertise_pause_in; // R7
			next_tx_word[ban_pkg::CW_C1_BIT] = advertise_asym_direction_in; // R8
			next_tx_word[ban_pkg::CW_FAULT_BIT] = advertise_fault_in; // R6
			next_tx_word[ban_pkg::CW_NONCE_LSB +: ban_pkg::NONCE_WIDTH] = nonce_state[4:0]; // R3
			next_tx_word[ban_pkg::CW_ABILITY_LSB +: ban_pkg::ABILITY_WIDTH] = ability; // R14
		end else if (local_next_page_request) begin
			next_tx_word = local_next_page_word; // R9
		end else begin
			next_tx_word = ban_pkg::NULL_MESSAGE; // R10
		end
		next_tx_word[ban_pkg::CW_NP_BIT] = local_next_page_request;
		next_tx_word[ban_pkg::CW_ACK_BIT] = (state == ban_pkg::ST_BASE_ACK) || (state == ban_pkg::ST_NEXT_ACK); // R12
	end

	// Active level of the next cycle, no page leaves on the way out
	assign next_active = (state != ban_pkg::ST_OFF) && (state != ban_pkg::ST_BYPASS) &&
		(state != ban_pkg::ST_DONE) && (next_state != ban_pkg::ST_OFF) &&
		(next_state != ban_pkg::ST_BYPASS) && (next_state != ban_pkg::ST_DONE);
	assign page_fire = sending & page_due & next_active;

	// Page interval timer, restarted outside negotiation
	assign sending = negotiation_active;
	assign page_due = (page_count == ban_pkg::PAGE_CNT_WIDTH'(ban_pkg::PAGE_CYCLES - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_count <= 7'h00;
		end else if (!sending || page_due) begin
			page_count <= 7'h00;
		end else begin
			page_count <= page_count + 7'h01;
		end
	end

	// Page and random bit sent once per interval
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_page.word <= 48'h000000000000;
			tx_page.strobe <= 1'b0;
			tx_random_bit <= 1'b0;
		end else begin
			tx_page.strobe <= page_fire;
			if (page_fire) begin
				tx_page.word <= next_tx_word;
				tx_random_bit <= random_state[6];
			end
		end
	end

	// Link state indications
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			negotiation_active <= 1'b0;
			pcs_connect <= 1'b0;
		end else begin
			negotiation_active <= next_active;
			pcs_connect <= (next_state == ban_pkg::ST_BYPASS) || (next_state == ban_pkg::ST_DONE); // R2
		end
	end

	// ************************************************************
	// Random generators
	// ************************************************************

	// Nonce reseeded while idle, advanced on each restart made outside ST_OFF and ST_BYPASS
	assign nonce_load = (state == ban_pkg::ST_OFF) || (state == ban_pkg::ST_BYPASS);
	assign random_taps = random_bit_poly_select ? ban_pkg::POLY_X7_X6_TAPS : ban_pkg::POLY_X7_X3_TAPS; // R4

	ban_lfsr #(
		.WIDTH(8)
	) nonce_gen (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(nonce_load),
		.seed(nonce_generator_seed), // R3
		.step(restart_pulse),
		.taps(ban_pkg::NONCE_TAPS),
		.state(nonce_state)
	);

	ban_lfsr #(
		.WIDTH(7)
	) random_gen (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(nonce_load),
		.seed(ban_pkg::RANDOM_SEED),
		.step(page_fire),
		.taps(random_taps),
		.state(random_state)
	);

endmodule // ban_autoneg_control

// ### ban_autoneg_control_sva.sv
// ********
// Port checker
// ********
module ban_autoneg_control_sva (
	input logic aclk,
	input logic aresetn,
	input ban_pkg::ban_axil_req_type axil_req,
	input ban_pkg::ban_axil_rsp_type axil_rsp,
	input ban_pkg::ban_page_type rx_page,
	input ban_pkg::ban_page_type tx_page,
	input logic tx_random_bit,
	input logic pcs_connect,
	input logic negotiation_active
);
	// Single clock domain
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_tx_when_active: assert property (tx_page.strobe |-> negotiation_active)
		else $error("page sent while idle");
	chk_pcs_excl: assert property (pcs_connect |-> !negotiation_active)
		else $error("pcs connected during pages");
	chk_rand_step: assert property ($changed(tx_random_bit) |-> tx_page.strobe || $past(tx_page.strobe))
		else $error("random bit moved off a page");
	chk_word_hold: assert property (!tx_page.strobe |-> $stable(tx_page.word))
		else $error("sent word changed between pages");
	chk_page_gap: assert property (tx_page.strobe |=> (!tx_page.strobe) [*8])
		else $error("pages too close");
	chk_rd_answer: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
		else $error("read answer late");
	chk_ar_block: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
		else $error("read taken while answer pending");
	chk_wr_answer: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
		|-> ##[1:3] axil_rsp.bvalid)
		else $error("write answer late");
	// Main scenarios
	cover property (pcs_connect && !negotiation_active);
	cover property (tx_page.strobe && tx_page.word[15]);
	cover property ($rose(negotiation_active));
endmodule // ban_autoneg_control_sva

bind ban_autoneg_control ban_autoneg_control_sva u_sva (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
	.axil_rsp(axil_rsp), .rx_page(rx_page), .tx_page(tx_page), .tx_random_bit(tx_random_bit),
	.pcs_connect(pcs_connect), .negotiation_active(negotiation_active));

// ### ban_partner_model.sv
// ********
// Link partner model
// ********
module ban_partner_model #(
	parameter int DELAY = 20
) (
	input logic aclk,
	input logic aresetn,
	input ban_pkg::ban_page_type tx_page,
	input logic np_more,
	output ban_pkg::ban_page_type rx_page = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// Answer each page with an acknowledged page
	always @(posedge aclk) begin
		rx_page.strobe <= 1'b0;
		rx_page.word <= ~rx_page.word; // Idle word toggles
		if (!aresetn) cnt <= 0;
		else if (tx_page.strobe) cnt <= DELAY;
		else if (cnt > 0) cnt <= cnt - 1;
		if (cnt == 1) begin
			rx_page.strobe <= 1'b1;
			rx_page.word <= 48'h3c5a00004001 | (48'(np_more) << 15);
		end
	end
endmodule // ban_partner_model

// ### tb.sv
// ********
// Testbench
// ********
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] EN = 32'h1 << ban_pkg::CTL_ENABLE_BIT;
	localparam logic [31:0] BYP = 32'h1 << ban_pkg::CTL_BYPASS_BIT;
	localparam logic [31:0] RST = 32'h1 << ban_pkg::CTL_RESTART_BIT;
	localparam logic [31:0] REQ = 32'h1 << ban_pkg::CTL_LOCAL_REQ_BIT;
	localparam logic [31:0] ACK = 32'h1 << ban_pkg::CTL_READ_ACK_BIT;
	localparam logic [31:0] POLY = 32'h1 << ban_pkg::CTL_POLY_BIT;
	localparam logic [31:0] ADV = 32'h7 | (32'h5555 << ban_pkg::ADV_ABILITY_LSB);
	logic aclk = 0, aresetn = 0, np_more = 1, rbit, pcs, act;
	ban_pkg::ban_axil_req_type req = '0;
	ban_pkg::ban_axil_rsp_type rsp;
	ban_pkg::ban_page_type rxp, txp;
	logic [31:0] rd;
	logic [47:0] w;
	logic [6:0] lf = 7'h01;
	logic psel = 1'b0;
	int miscompares = 0, total_checks = 0, cycles = 0;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
	// Clock
	always #50 aclk = ~aclk;
	ban_autoneg_control DUT (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .rx_page(rxp),
		.tx_page(txp), .tx_random_bit(rbit), .pcs_connect(pcs), .negotiation_active(act));
	ban_partner_model u_lp (.aclk(aclk), .aresetn(aresetn), .tx_page(txp), .np_more(np_more), .rx_page(rxp));
	// Hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			final_report;
		end
	end
	// Random bit reference, stepped on every sent page
	always @(posedge aclk) begin
		if (txp.strobe === 1'b1) begin
			`CHK(rbit, lf[6])
			lf <= {lf[5:0], ^(lf & (psel ? ban_pkg::POLY_X7_X6_TAPS : ban_pkg::POLY_X7_X3_TAPS))};
		end
	end
	task final_report;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = ban_pkg::RESP_OKAY);
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		{req.awvalid, req.wvalid, req.bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
		`CHK(rsp.bresp, e)
	endtask
	task automatic rdr(input logic [7:0] a, input logic [1:0] e = ban_pkg::RESP_OKAY);
		@(posedge aclk);
		req.araddr <= a;
		{req.arvalid, req.rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
		rd = rsp.rdata;
		`CHK(rsp.rresp, e)
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1,
		input logic [1:0] e = ban_pkg::RESP_OKAY);
		rdr(a, e);
		`CHK(rd & m, x)
	endtask
	task automatic wt;
		do @(posedge aclk); while (txp.strobe !== 1'b1);
		w = txp.word;
	endtask
	task automatic ws(input int b);
		do rdr(ban_pkg::OFS_STATUS); while (rd[b] !== 1'b1);
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdc(ban_pkg::OFS_STATUS, 32'h0);
		rdc(ban_pkg::OFS_SEED, 32'h1);
		rdc(8'h20, 32'h0, '1, ban_pkg::RESP_SLVERR);
		wr(ban_pkg::OFS_STATUS, 32'h1, ban_pkg::RESP_SLVERR);
		wr(ban_pkg::OFS_SEED, 32'ha5);
		rdc(ban_pkg::OFS_SEED, 32'ha5);
		wr(ban_pkg::OFS_ADVERTISE, ADV);
		wr(ban_pkg::OFS_CONTROL, EN);
		wt;
		`CHK(w[ban_pkg::CW_C0_BIT], 1'b1)
		`CHK(w[ban_pkg::CW_C1_BIT], 1'b1)
		`CHK(w[ban_pkg::CW_FAULT_BIT], 1'b1)
		`CHK(w[ban_pkg::CW_ABILITY_LSB +: 15], 15'h5555)
		`CHK({act, w[ban_pkg::CW_NP_BIT]}, 2'h2)
		wt;
		wt;
		`CHK(w, ban_pkg::NULL_MESSAGE)
		ws(ban_pkg::STS_PARTNER_VALID_BIT);
		rdc(ban_pkg::OFS_PARTNER_PAGE_LO, 32'h0000c001);
		np_more <= 1'b0;
		wr(ban_pkg::OFS_CONTROL, EN | ACK);
		rdc(ban_pkg::OFS_STATUS, 32'h0, 32'h1 << ban_pkg::STS_PARTNER_VALID_BIT);
		ws(ban_pkg::STS_PARTNER_VALID_BIT);
		rdc(ban_pkg::OFS_PARTNER_PAGE_LO, 32'h00004001);
		wr(ban_pkg::OFS_CONTROL, EN | ACK);
		ws(ban_pkg::STS_PCS_BIT);
		`CHK({pcs, act}, 2'h2)
		wr(ban_pkg::OFS_LOCAL_PAGE_LO, 32'h89ab0def);
		wr(ban_pkg::OFS_LOCAL_PAGE_HI, 32'h4567);
		wr(ban_pkg::OFS_CONTROL, EN | REQ | RST | POLY);
		psel <= 1'b1;
		wt;
		`CHK({act, w[ban_pkg::CW_NP_BIT]}, 2'h3)
		wt;
		wt;
		`CHK(w, 48'h456789ab8def)
		wr(ban_pkg::OFS_CONTROL, EN | BYP);
		rdc(ban_pkg::OFS_STATUS, 32'h2, 32'h3);
		wr(ban_pkg::OFS_CONTROL, 32'h0);
		rdc(ban_pkg::OFS_STATUS, 32'h0, 32'h3);
		`CHK({pcs, act}, 2'h0)
		final_report;
	end
endmodule // tb
